// [bench/pwm_pin_load.sv]
`timescale 1ns/10ps
`default_nettype none

// load on both waveform pins; high time is summed while measure is up
module pwm_pin_load (
  input  wire logic        sys_clk,
  input  wire logic [1:0]  pin_out,
  input  wire logic [1:0]  pin_oe,
  input  wire logic        measure,
  output var  logic [31:0] high_a,
  output var  logic [31:0] high_b
);
  logic [1:0] level;

  // a pull-down sets an undriven pin low, so a stale level cannot pass
  assign level = pin_oe & pin_out;

  // counts restart whenever measure drops, so every window starts clean
  always_ff @(posedge sys_clk) begin
    if (!measure) begin
      high_a <= 32'h0;
      high_b <= 32'h0;
    end else begin
      high_a <= high_a + 32'(level[0]);
      high_b <= high_b + 32'(level[1]);
    end
  end
endmodule : pwm_pin_load

`default_nettype wire

// [bench/tb_dual_slope_pwm_timer16.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_dual_slope_pwm_timer16;
  import pwm_timer_pkg::*;
  logic        sys_clk, arst_n, read, write, waitrequest, measure;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, rd, high_a, high_b;
  logic [1:0]  pin_out, pin_oe;
  int          mismatches, checked, cycles;
  logic [3:0]  modes [7] = '{MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CP, MODE_PFC_A,
                             MODE_PC_CP, MODE_PC_A};

  dual_slope_pwm_timer16 #(.DIV_W(10)) dual_slope_pwm_timer16_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_out(pin_out), .pin_oe(pin_oe));

  pwm_pin_load pwm_pin_load_i (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .measure(measure), .high_a(high_a), .high_b(high_b));

  ////////////////////////////////////////
  // clock, and a cycle ceiling well above the planned run
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // non-blocking count, so the main sequence always reads the pre-edge value
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////
  // bus cycles; waitrequest and read data are taken at the accepting rising edge
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    write <= wr;
    read <= !wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_xfer

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask : bus_write

  task automatic bus_read(input logic [4:0] a);
    bus_xfer(1'b0, a, 32'h0);
  endtask : bus_read

  task automatic check_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_reg

  task automatic check_cnt(input string nm, input int e, input logic [31:0] g);
    checked++;
    if (g !== 32'(e)) begin
      mismatches++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : check_cnt

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////
  // expectations: high cycles in a window of w*n*t cycles
  function automatic int exp_high(int w, int n, int t, int c, logic [1:0] s, logic d);
    if (!d) return 0;
    if (s == SEL_TOGGLE) return w * n * t / 2;
    if (s == SEL_INV) return w * n * (t - c);
    return w * n * c;
  endfunction : exp_high

  function automatic int div_of(logic [2:0] ps);
    case (ps)
      PS_8: return 8;
      PS_64: return 64;
      PS_256: return 256;
      PS_1024: return 1024;
      default: return 1;
    endcase
  endfunction : div_of

  function automatic int top_of(logic [3:0] m, int t);
    if (m == MODE_PC8) return int'(TOP_8);
    if (m == MODE_PC9) return int'(TOP_9);
    if (m == MODE_PC10) return int'(TOP_10);
    return t;
  endfunction : top_of

  // stop, load, start, let one period pass, then measure both pins and flags
  task automatic run_pwm(input logic [3:0] m, input logic [2:0] ps, input int t, ca, cb,
                         input logic [1:0] sa, sb, dir);
    int n, w, tp, ea;
    logic [31:0] ef;
    n = div_of(ps);
    tp = top_of(m, t);
    w = (sa == SEL_TOGGLE) ? 4 : 2;
    ea = (m == MODE_PFC_A || m == MODE_PC_A) ? tp : ca;
    bus_write(OFF_CTRL, 32'h0);
    bus_write(OFF_CMP_A, 32'(ea));
    bus_write(OFF_CMP_B, 32'(cb));
    bus_write(OFF_CAP_TOP, 32'(tp));
    bus_write(OFF_COUNT, 32'h0);
    bus_write(OFF_PINS, {30'h0, dir});
    bus_write(OFF_FLAGS, 32'hf);
    bus_write(OFF_CTRL, {21'h0, ps, sb, sa, m});
    repeat (2 * n * tp + 8) @(posedge sys_clk);
    measure <= 1'b1;
    repeat (w * n * tp) @(posedge sys_clk);
    measure <= 1'b0;
    @(negedge sys_clk);
    check_cnt("high_a", exp_high(w, n, tp, ea, sa, dir[0]), high_a);
    if (cb <= tp) check_cnt("high_b", exp_high(w, n, tp, cb, sb, dir[1]), high_b);
    @(posedge sys_clk);
    bus_read(OFF_FLAGS);
    ef = {28'h0, m == MODE_PFC_CP || m == MODE_PC_CP, cb <= tp, 2'b11};
    check_reg("flags", ef, rd);
    $display("test pwm mode %0d top %0d done", m, tp);
  endtask : run_pwm

  ////////////////////////////////////////
  // main sequence: reset, idle pins, count order, corner cases, random runs
  initial begin : main
    int prev, nxt, up, t0, t;
    logic [3:0] m;
    {read, write, measure} = 3'h0;
    address = 5'h0;
    writedata = 32'h0;
    byteenable = 4'h0;
    arst_n = 1'b0;
    void'($urandom(32'h47612e42));
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      bus_read(5'(i * 4));
      check_reg("reset_reg", 32'h0, rd);
    end
    $display("test reset done");
    // select off: pin shows its port level, driver gated by direction
    foreach (modes[i]) if (i < 2) begin
      bus_write(OFF_PINS, i == 0 ? 32'h9 : 32'h4);
      repeat (2) @(posedge sys_clk);
      check_reg("pins", i == 0 ? 32'h9 : 32'h4, {28'h0, pin_out, pin_oe});
    end
    $display("test idle pins done");
    // count order near top and floor, each step one tick of 64 cycles
    bus_write(OFF_CMP_A, 32'h3);
    bus_write(OFF_CTRL, {21'h0, PS_64, 4'h0, MODE_PFC_A});
    prev = 0;
    up = 1;
    t0 = cycles;
    for (int k = 0; k < 7; k++) begin
      nxt = up ? prev + 1 : prev - 1;
      up = (nxt == 3) ? 0 : (nxt == 0) ? 1 : up;
      do bus_read(OFF_COUNT); while (rd === 32'(prev));
      check_reg("count", 32'(nxt), rd);
      if (k > 0) check_cnt("step_len", 1, 32'(cycles - t0 > 60 && cycles - t0 < 68));
      t0 = cycles;
      prev = nxt;
    end
    $display("test count order done");
    run_pwm(MODE_PFC_A, PS_1, 3, 0, 0, SEL_NONINV, SEL_NONINV, 2'b11);
    run_pwm(MODE_PC_A, PS_8, 20, 0, 20, SEL_TOGGLE, SEL_INV, 2'b11);
    run_pwm(MODE_PFC_A, PS_1, 17, 0, 9, SEL_TOGGLE, SEL_NONINV, 2'b10);
    run_pwm(MODE_PFC_CP, PS_1, 10, 4, 12, SEL_INV, SEL_INV, 2'b11);
    for (int p = 1; p <= 5; p++) run_pwm(MODE_PFC_A, 3'(p), 3, 0, 1, SEL_NONINV,
                                         SEL_INV, 2'b11);
    // every decoded mode once; compares and selects random, TOP and prescale random above mode 3, both pins output
    foreach (modes[j]) begin
      m = modes[j];
      t = 3 + $urandom % 30;
      run_pwm(m, m < 4'h4 ? PS_1 : 3'(1 + $urandom % 2), t, $urandom % (t + 1),
              $urandom % (t + 1), 2'(2 + $urandom % 2), 2'(2 + $urandom % 2), 2'b11);
    end
    end_of_test();
  end
endmodule : tb_dual_slope_pwm_timer16

`default_nettype wire

// [core/dual_slope_pwm_timer16.sv]
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - phase correct mode loads compare buffers at TOP; changed TOP may be asymmetric
// - select two gives non-inverted PWM, three gives inverted PWM
// - waveform reaches the pin only when its direction bit selects output
// - non-inverted clears on up-count match, sets on down-count match; inverted reverses
// - tick dividers 1, 8, 64, 256, 1024; period is 2 x divider x TOP
// - compare 0 holds output low, compare TOP holds high; inverted opposite
// - mode 11 with channel A select 1 toggles output A at half duty
// - mode 9 with channel A select 1 toggles output A at half duty
// - modes 8 and 9 count 0 up to TOP and back to 0
// - mode 8 takes TOP from capture, mode 9 from compare A
// - counter holds TOP for exactly one tick before counting down
// - TOP from 0x0003 up to the maximum count is supported
// - match flag set on a tick in a dual-slope mode when counter equals that channel's compare value
// - frequency correct mode sets overflow at 0 with the buffer update
// - frequency correct mode flags compare A or capture at TOP
// - software keeps TOP at or above compare values, else no match occurs
// - updating at 0 keeps rising and falling slopes equal in length
// - fully synchronous; the prescaled tick is a clock enable only
// - events at 0 follow the same timing as events at TOP
// - capture writes go straight to TOP; compare A writes are buffered
// - modes 1, 2, 3, 10, 11 are phase correct with their TOP sources
// - phase correct mode sets overflow each time the counter reaches 0
// - select zero disconnects the waveform, pin keeps its port level
module dual_slope_pwm_timer16
  import pwm_timer_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output logic             waitrequest,
  output var  logic [1:0]  pin_out,
  output var  logic [1:0]  pin_oe
);

  if (DIV_W < 10) begin : g_bad_div
    $error("DIV_W too small for the 1024 divider");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] be_merge(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge
  function automatic logic is_dual(input logic [3:0] m);
    is_dual = m inside {MODE_PC8, MODE_PC9, MODE_PC10, MODE_PFC_CP,
                        MODE_PFC_A, MODE_PC_CP, MODE_PC_A};
  endfunction : is_dual
  function automatic logic is_pfc(input logic [3:0] m);
    is_pfc = (m == MODE_PFC_CP) || (m == MODE_PFC_A);
  endfunction : is_pfc
  function automatic logic [9:0] tick_mask(input logic [2:0] s);
    case (s)
      PS_8:    tick_mask = MASK_8;
      PS_64:   tick_mask = MASK_64;
      PS_256:  tick_mask = MASK_256;
      PS_1024: tick_mask = MASK_1024;
      default: tick_mask = MASK_1;
    endcase
  endfunction : tick_mask

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0]       mode;
  logic [1:0]       sel [2];
  logic [2:0]       presc;
  logic [15:0]      cmp [2];
  logic [15:0]      buf_v [2];
  logic [15:0]      cap_top;
  logic [15:0]      count;
  slope_e           slope;
  logic [3:0]       flags;
  logic [1:0]       dir;
  logic [1:0]       level;
  logic [1:0]       wave;
  logic [DIV_W-1:0] div_cnt;
  logic             ack;
  logic             wr_go;
  logic             count_wr;
  logic             tick;
  logic             dual;
  logic [15:0]      top;
  logic             at_top;
  logic             at_floor;
  logic             up_now;
  logic             top_is_a;
  logic [3:0]       flag_set;
  logic [3:0]       flag_clr;

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state per access, unmapped reads give zero
  assign waitrequest = (read || write) && !ack;
  assign wr_go       = write && ack;
  assign count_wr    = wr_go && (address == OFF_COUNT);

  // ack pulses once per held request so the master sees exactly one edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  // read data is sampled on the wait edge and held through the accept edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack) begin
      case (address)
        OFF_CTRL:    readdata <= 32'({presc, sel[1], sel[0], mode});
        OFF_CMP_A:   readdata <= 32'(buf_v[0]);
        OFF_CMP_B:   readdata <= 32'(buf_v[1]);
        OFF_CAP_TOP: readdata <= 32'(cap_top);
        OFF_COUNT:   readdata <= 32'(count);
        OFF_FLAGS:   readdata <= 32'(flags);
        OFF_PINS:    readdata <= 32'({level, dir});
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  // control, capture top and pin registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode    <= MODE_RESET;
      sel[0]  <= SEL_OFF;
      sel[1]  <= SEL_OFF;
      presc   <= PRESC_RESET;
      cap_top <= VALUE_RESET;
      dir     <= 2'h0;
      level   <= 2'h0;
    end else if (wr_go) begin
      if (address == OFF_CTRL && byteenable[0]) begin
        mode   <= writedata[CTRL_MODE_LSB +: 4];
        sel[0] <= writedata[CTRL_SEL_A_LSB +: 2];
        sel[1] <= writedata[CTRL_SEL_B_LSB +: 2];
      end
      if (address == OFF_CTRL && byteenable[1]) begin
        presc <= writedata[CTRL_PRESC_LSB +: 3];
      end
      if (address == OFF_CAP_TOP) begin
        cap_top <= be_merge(cap_top, writedata, byteenable);
      end
      if (address == OFF_PINS && byteenable[0]) begin
        dir   <= writedata[PINS_DIR_LSB +: 2];
        level <= writedata[PINS_LVL_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: tick is an enable on sys_clk, never a clock of its own
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= '0;
    end else if (presc == PS_STOP) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  assign tick = (presc inside {PS_1, PS_8, PS_64, PS_256, PS_1024})
             && ((div_cnt & DIV_W'(tick_mask(presc))) == DIV_W'(tick_mask(presc)));

  ////////////////////////////////////////////////////////////////////////////
  // top selection and position decode
  assign dual     = is_dual(mode);
  assign top_is_a = (mode == MODE_PFC_A) || (mode == MODE_PC_A);

  always_comb begin
    case (mode)
      MODE_PC8:                top = TOP_8;
      MODE_PC9:                top = TOP_9;
      MODE_PC10:               top = TOP_10;
      MODE_PFC_CP, MODE_PC_CP: top = cap_top;
      MODE_PFC_A, MODE_PC_A:   top = cmp[0];
      default:                 top = TOP_MAX;
    endcase
  end

  assign at_top   = (count == top);
  assign at_floor = (count == COUNT_FLOOR);
  // a match at 0 belongs to the up slope, a match at TOP to the down slope
  assign up_now   = ((slope == cnt_up) && !at_top) || at_floor;

  ////////////////////////////////////////////////////////////////////////////
  // dual-slope counter; a TOP lowered below the count wraps via 0xffff
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= COUNT_FLOOR;
      slope <= cnt_up;
    end else if (count_wr) begin
      count <= be_merge(count, writedata, byteenable);
    end else if (tick && dual) begin
      case (slope)
        cnt_up: begin
          if (at_top) begin
            slope <= cnt_down;
            count <= count - COUNT_STEP;
          end else begin
            count <= count + COUNT_STEP;
          end
        end
        cnt_down: begin
          if (at_floor) begin
            slope <= cnt_up;
            count <= count + COUNT_STEP;
          end else begin
            count <= count - COUNT_STEP;
          end
        end
        default: slope <= cnt_up;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel buffers, active compares and waveform state
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    localparam logic [4:0] OFF_CMP = (ch == 0) ? OFF_CMP_A : OFF_CMP_B;

    // buffer takes every write; the active copy follows at update points in dual-slope modes, every cycle otherwise
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        buf_v[ch] <= VALUE_RESET;
      end else if (wr_go && address == OFF_CMP) begin
        buf_v[ch] <= be_merge(buf_v[ch], writedata, byteenable);
      end
    end

    // update at TOP (phase correct) or at 0 (frequency correct)
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        cmp[ch] <= VALUE_RESET;
      end else if (!dual) begin
        cmp[ch] <= buf_v[ch];
      end else if (tick && (is_pfc(mode) ? at_floor : at_top)) begin
        cmp[ch] <= buf_v[ch];
      end
    end

    // waveform state; holds its level while the channel is disconnected
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        wave[ch] <= 1'b0;
      end else if (tick && dual && count == cmp[ch]) begin
        case (sel[ch])
          SEL_TOGGLE: wave[ch] <= (ch == 0 && top_is_a) ? !wave[ch] : wave[ch];
          SEL_NONINV: wave[ch] <= !up_now;
          SEL_INV:    wave[ch] <= up_now;
          default:    wave[ch] <= wave[ch];
        endcase
      end
    end

    // pin drive: waveform only when connected, driver only when set to output
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        pin_out[ch] <= 1'b0;
        pin_oe[ch]  <= 1'b0;
      end else begin
        pin_out[ch] <= (sel[ch] == SEL_OFF) ? level[ch] : wave[ch];
        pin_oe[ch]  <= dir[ch];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, write one to clear; a set in the same cycle wins
  always_comb begin
    flag_set               = 4'h0;
    flag_set[FLAG_OVF]     = tick && dual && at_floor;
    flag_set[FLAG_MATCH_A] = tick && dual && count == cmp[0];
    flag_set[FLAG_MATCH_B] = tick && dual && count == cmp[1];
    flag_set[FLAG_CAPTURE] = tick && at_top
                          && (mode == MODE_PFC_CP || mode == MODE_PC_CP);
    flag_clr = (wr_go && address == OFF_FLAGS && byteenable[0]) ?
               writedata[3:0] : 4'h0;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= 4'h0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_top_hold_turn: assert property (
    tick && dual && !count_wr && slope == cnt_up && at_top
    |=> count == $past(top) - COUNT_STEP && slope == cnt_down)
    else $error("counter did not turn after one tick at TOP");
  a_floor_turn: assert property (
    tick && dual && !count_wr && slope == cnt_down && at_floor
    |=> count == COUNT_STEP && slope == cnt_up)
    else $error("counter did not turn at zero");
  a_ovf_at_floor: assert property (
    tick && dual && at_floor |=> flags[FLAG_OVF])
    else $error("overflow flag missing at zero");
  a_pfc_update_floor: assert property (
    tick && is_pfc(mode) && at_floor
    |=> cmp[1] == $past(buf_v[1]) && flags[FLAG_OVF])
    else $error("buffer not loaded with overflow at zero");
  a_pc_update_top: assert property (
    tick && dual && !is_pfc(mode) && at_top |=> cmp[1] == $past(buf_v[1]))
    else $error("buffer not loaded at TOP");
  a_match_flag_b: assert property (
    tick && dual && count == cmp[1] |=> flags[FLAG_MATCH_B])
    else $error("match flag B not set");
  // the pin stage follows whatever select stood one cycle after the match
  a_noninv_slopes: assert property (
    tick && dual && sel[1] == SEL_NONINV && count == cmp[1]
    |=> wave[1] == !$past(up_now)
    ##1 pin_out[1] == ($past(sel[1]) == SEL_OFF ? $past(level[1]) : $past(wave[1])))
    else $error("non-inverted output wrong at match");
  a_inv_slopes: assert property (
    tick && dual && sel[1] == SEL_INV && count == cmp[1] |=> wave[1] == $past(up_now))
    else $error("inverted output wrong at match");
  a_toggle_half: assert property (
    tick && top_is_a && sel[0] == SEL_TOGGLE && count == cmp[0] |=> wave[0] != $past(wave[0]))
    else $error("output A did not toggle");
  a_capture_flag: assert property (
    tick && mode == MODE_PFC_CP && at_top |=> flags[FLAG_CAPTURE])
    else $error("capture flag missing at TOP");
  a_capture_direct: assert property (
    wr_go && address == OFF_CAP_TOP && byteenable == 4'hf
    |=> cap_top == $past(writedata[15:0]))
    else $error("capture top not written directly");
  a_tick_div8: assert property (
    tick && presc == PS_8 |=> (!tick || presc != PS_8) [*7])
    else $error("divide by 8 tick spacing wrong");
  a_pin_release: assert property (
    !dir[0] |=> !pin_oe[0])
    else $error("pin driven while set to input");
  c_pc_top:     cover property (tick && mode == MODE_PC_A && at_top);
  c_pfc_floor:  cover property (tick && mode == MODE_PFC_CP && at_floor);
  c_toggle:     cover property (tick && sel[0] == SEL_TOGGLE && top_is_a && count == cmp[0]);
  c_inv_match:  cover property (tick && sel[1] == SEL_INV && count == cmp[1]);

endmodule : dual_slope_pwm_timer16

`default_nettype wire

// [core/pwm_timer_pkg.sv]
package pwm_timer_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL    = 5'h00;
  localparam logic [4:0] OFF_CMP_A   = 5'h04;
  localparam logic [4:0] OFF_CMP_B   = 5'h08;
  localparam logic [4:0] OFF_CAP_TOP = 5'h0c;
  localparam logic [4:0] OFF_COUNT   = 5'h10;
  localparam logic [4:0] OFF_FLAGS   = 5'h14;
  localparam logic [4:0] OFF_PINS    = 5'h18;

  // control word fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_SEL_A_LSB = 4;
  localparam int CTRL_SEL_B_LSB = 6;
  localparam int CTRL_PRESC_LSB = 8;

  // flag bits, pin word fields
  localparam int FLAG_OVF      = 0;
  localparam int FLAG_MATCH_A  = 1;
  localparam int FLAG_MATCH_B  = 2;
  localparam int FLAG_CAPTURE  = 3;
  localparam int PINS_DIR_LSB  = 0;
  localparam int PINS_LVL_LSB  = 2;

  // reset values
  localparam logic [3:0]  MODE_RESET  = 4'h0;
  localparam logic [2:0]  PRESC_RESET = 3'h0;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

  // waveform modes handled here
  localparam logic [3:0] MODE_PC8    = 4'h1;
  localparam logic [3:0] MODE_PC9    = 4'h2;
  localparam logic [3:0] MODE_PC10   = 4'h3;
  localparam logic [3:0] MODE_PFC_CP = 4'h8;
  localparam logic [3:0] MODE_PFC_A  = 4'h9;
  localparam logic [3:0] MODE_PC_CP  = 4'ha;
  localparam logic [3:0] MODE_PC_A   = 4'hb;

  // fixed tops and count limits
  localparam logic [15:0] TOP_8       = 16'h00ff;
  localparam logic [15:0] TOP_9       = 16'h01ff;
  localparam logic [15:0] TOP_10      = 16'h03ff;
  localparam logic [15:0] TOP_MAX     = 16'hffff;
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] COUNT_STEP  = 16'h0001;

  // output behaviour select codes
  localparam logic [1:0] SEL_OFF    = 2'h0;
  localparam logic [1:0] SEL_TOGGLE = 2'h1;
  localparam logic [1:0] SEL_NONINV = 2'h2;
  localparam logic [1:0] SEL_INV    = 2'h3;

  // prescale selects and their divider masks
  localparam logic [2:0] PS_STOP = 3'h0;
  localparam logic [2:0] PS_1    = 3'h1;
  localparam logic [2:0] PS_8    = 3'h2;
  localparam logic [2:0] PS_64   = 3'h3;
  localparam logic [2:0] PS_256  = 3'h4;
  localparam logic [2:0] PS_1024 = 3'h5;
  localparam logic [9:0] MASK_1    = 10'h000;
  localparam logic [9:0] MASK_8    = 10'h007;
  localparam logic [9:0] MASK_64   = 10'h03f;
  localparam logic [9:0] MASK_256  = 10'h0ff;
  localparam logic [9:0] MASK_1024 = 10'h3ff;

  typedef enum logic {cnt_up, cnt_down} slope_e;

endpackage : pwm_timer_pkg
